/* scpi_status.sv */
// Status register groups of the acquisition instrument, command driven
`default_nettype none
module scpi_status (
  input wire logic clock,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire scpi_status_pkg::cmd_t cmd_op,
  input wire logic [15:0] cmd_data,
  input wire logic scan_running,
  input wire logic panel_cfg_change,
  input wire logic [15:0] reading_count,
  input wire logic [15:0] ques_cond_in,
  input wire logic [7:0] std_event_in,
  input wire logic [15:0] alarm_event_in,
  input wire logic alarm_queue_not_empty,
  input wire logic error_queue_not_empty,
  input wire logic message_available,
  output logic resp_valid,
  output logic [15:0] resp_data,
  output logic [7:0] status_byte,
  output logic service_request
);
  // Register group carriers, one per group
  status_group_if #(.W(scpi_status_pkg::REG_W)) oper_if ();
  status_group_if #(.W(scpi_status_pkg::REG_W)) ques_if ();
  status_group_if #(.W(scpi_status_pkg::REG_W)) std_if ();
  status_group_if #(.W(scpi_status_pkg::REG_W)) alarm_if ();

  // Group-wide command strobes
  logic do_cls;
  logic do_preset;
  logic do_factory;
  logic do_poll;

  // Operation condition state
  logic cfg_q;
  logic scan_start;
  logic [15:0] oper_cond_d;
  logic [15:0] oper_cond_q;

  // Questionable condition and its edge history
  logic [15:0] ques_cond_q;
  logic [15:0] ques_prev_q;

  // Alarm condition, queue edge history and event sources
  logic [15:0] alarm_cond_d;
  logic [15:0] alarm_cond_q;
  logic alarm_prev_q;
  logic [15:0] alarm_set_d;

  // Standard event sources plus the power-on marker
  logic pon_q;
  logic [15:0] std_set_d;

  // Status byte, its enable mask and the request edge
  logic [7:0] sre_q;
  logic [7:0] stb_base;
  logic [7:0] stb_d;
  logic [7:0] poll_d;
  logic mss_d;
  logic mss_q;

  // Memory threshold
  logic thr_we;
  logic [15:0] thr_q;
  logic level_q;

  // Query answer before it is registered
  logic [15:0] resp_d;
  logic query_d;

  // One strobe per group-wide command; only a valid command counts
  assign do_cls = cmd_valid && (cmd_op == scpi_status_pkg::CMD_CLS);
  assign do_preset = cmd_valid && (cmd_op == scpi_status_pkg::CMD_PRESET);
  assign do_factory = cmd_valid && (cmd_op == scpi_status_pkg::CMD_FACTORY_RST);
  assign do_poll = cmd_valid && (cmd_op == scpi_status_pkg::CMD_SERIAL_POLL);
  assign thr_we = cmd_valid && (cmd_op == scpi_status_pkg::CMD_THR_W);

  // Panel edit flag; an edit in the scan-start cycle wins over the clear
  always_ff @(posedge clock)
  begin
    if (rst)
      cfg_q <= 1'b0;
    else if (panel_cfg_change)
      cfg_q <= 1'b1;
    else if (scan_start)
      cfg_q <= 1'b0;
  end

  // Rising edge of the running input marks a new scan
  assign scan_start = scan_running && !oper_cond_q[scpi_status_pkg::OPER_SCAN_BIT];

  // Operation condition; unused positions stay zero
  always_comb
  begin
    oper_cond_d = scpi_status_pkg::ZERO16;
    oper_cond_d[scpi_status_pkg::OPER_SCAN_BIT] = scan_running;
    oper_cond_d[scpi_status_pkg::OPER_CFG_BIT] = cfg_q;
    oper_cond_d[scpi_status_pkg::OPER_MEM_BIT] = level_q;
  end

  // Condition register, also the edge history of the event bits
  always_ff @(posedge clock)
  begin
    if (rst)
      oper_cond_q <= scpi_status_pkg::ZERO16;
    else
      oper_cond_q <= oper_cond_d;
  end

  // Events latch on rising condition bits, so a held threshold fires once
  assign oper_if.set = oper_cond_d & ~oper_cond_q;
  assign oper_if.clr_event = do_cls ||
    (cmd_valid && (cmd_op == scpi_status_pkg::CMD_OPER_EVT_Q));
  assign oper_if.en_we = cmd_valid && (cmd_op == scpi_status_pkg::CMD_OPER_EN_W);
  assign oper_if.en_clr = do_preset;
  assign oper_if.en_wdata = cmd_data;

  // Operation group
  status_group #(
    .USED(scpi_status_pkg::OPER_USED)
  ) u_oper (
    .clock(clock),
    .rst(rst),
    .g(oper_if)
  );

  // Memory threshold store and level detector
  mem_threshold u_thr (
    .clock(clock),
    .rst(rst),
    .thr_we(thr_we),
    .thr_wdata(cmd_data),
    .reading_count(reading_count),
    .thr_q(thr_q),
    .level_q(level_q)
  );

  // Questionable condition mirrors its inputs; factory reset blanks it
  // for one cycle only, since the inputs are live levels
  always_ff @(posedge clock)
  begin
    if (rst || do_factory)
      ques_cond_q <= scpi_status_pkg::ZERO16;
    else
      ques_cond_q <= ques_cond_in;
  end

  // Edge history kept apart so a factory reset raises no false events
  always_ff @(posedge clock)
  begin
    if (rst)
      ques_prev_q <= scpi_status_pkg::ZERO16;
    else
      ques_prev_q <= ques_cond_in;
  end

  // Questionable events latch until queried or cleared
  assign ques_if.set = ques_cond_in & ~ques_prev_q;
  assign ques_if.clr_event = do_cls ||
    (cmd_valid && (cmd_op == scpi_status_pkg::CMD_QUES_EVT_Q));
  assign ques_if.en_we = cmd_valid && (cmd_op == scpi_status_pkg::CMD_QUES_EN_W);
  assign ques_if.en_clr = do_preset;
  assign ques_if.en_wdata = cmd_data;

  // Questionable group
  status_group #(
    .USED(scpi_status_pkg::QUES_USED)
  ) u_ques (
    .clock(clock),
    .rst(rst),
    .g(ques_if)
  );

  // Power-on marker stands for the first cycle after reset
  always_ff @(posedge clock)
  begin
    if (rst)
      pon_q <= 1'b1;
    else
      pon_q <= 1'b0;
  end

  // Standard event sources; the marker joins the power-on position
  always_comb
  begin
    std_set_d = scpi_status_pkg::ZERO16;
    std_set_d[7:0] = std_event_in;
    std_set_d[scpi_status_pkg::STD_PON_BIT] = std_event_in[scpi_status_pkg::STD_PON_BIT] || pon_q;
  end

  // Only clear-status empties the standard events; a query leaves them
  assign std_if.set = std_set_d;
  assign std_if.clr_event = do_cls;
  assign std_if.en_we = cmd_valid && (cmd_op == scpi_status_pkg::CMD_ESE_W);
  assign std_if.en_clr = 1'b0;
  assign std_if.en_wdata = cmd_data;

  // Standard event group
  status_group #(
    .USED(scpi_status_pkg::STD_USED)
  ) u_std (
    .clock(clock),
    .rst(rst),
    .g(std_if)
  );

  // Alarm condition holds only the queue flag
  always_comb
  begin
    alarm_cond_d = scpi_status_pkg::ZERO16;
    alarm_cond_d[scpi_status_pkg::ALARM_QUEUE_BIT] = alarm_queue_not_empty;
  end

  // Alarm condition register
  always_ff @(posedge clock)
  begin
    if (rst || do_factory)
      alarm_cond_q <= scpi_status_pkg::ZERO16;
    else
      alarm_cond_q <= alarm_cond_d;
  end

  // Queue flag history for its event edge
  always_ff @(posedge clock)
  begin
    if (rst)
      alarm_prev_q <= 1'b0;
    else
      alarm_prev_q <= alarm_queue_not_empty;
  end

  // Limit alarms arrive as pulses; the queue bit latches on its rise
  always_comb
  begin
    alarm_set_d = alarm_event_in;
    alarm_set_d[scpi_status_pkg::ALARM_QUEUE_BIT] =
      alarm_event_in[scpi_status_pkg::ALARM_QUEUE_BIT] ||
      (alarm_queue_not_empty && !alarm_prev_q);
  end

  // Alarm events latch until queried or cleared
  assign alarm_if.set = alarm_set_d;
  assign alarm_if.clr_event = do_cls ||
    (cmd_valid && (cmd_op == scpi_status_pkg::CMD_ALARM_EVT_Q));
  assign alarm_if.en_we = cmd_valid && (cmd_op == scpi_status_pkg::CMD_ALARM_EN_W);
  assign alarm_if.en_clr = do_preset;
  assign alarm_if.en_wdata = cmd_data;

  // Alarm group
  status_group #(
    .USED(scpi_status_pkg::ALARM_USED)
  ) u_alarm (
    .clock(clock),
    .rst(rst),
    .g(alarm_if)
  );

  // Status byte enable; neither clear-status nor preset touches it
  always_ff @(posedge clock)
  begin
    if (rst)
      sre_q <= 8'h00;
    else if (cmd_valid && (cmd_op == scpi_status_pkg::CMD_SRE_W))
      sre_q <= cmd_data[7:0];
  end

  // Status byte; the master summary position never feeds itself
  always_comb
  begin
    stb_base = 8'h00;
    stb_base[scpi_status_pkg::STB_ALARM_BIT] = alarm_if.summary;
    stb_base[scpi_status_pkg::STB_ERRQ_BIT] = error_queue_not_empty;
    stb_base[scpi_status_pkg::STB_QUES_BIT] = ques_if.summary;
    stb_base[scpi_status_pkg::STB_MAV_BIT] = message_available;
    stb_base[scpi_status_pkg::STB_STD_BIT] = std_if.summary;
    stb_base[scpi_status_pkg::STB_OPER_BIT] = oper_if.summary;
    mss_d = |(stb_base & sre_q);
    stb_d = stb_base;
    stb_d[scpi_status_pkg::STB_MSS_BIT] = mss_d;
    poll_d = stb_base;
    poll_d[scpi_status_pkg::STB_MSS_BIT] = service_request;
  end

  // Summary history for the request edge
  always_ff @(posedge clock)
  begin
    if (rst)
      mss_q <= 1'b0;
    else
      mss_q <= mss_d;
  end

  // Request latch; a new summary edge beats a poll in the same cycle
  always_ff @(posedge clock)
  begin
    if (rst)
      service_request <= 1'b0;
    else if (mss_d && !mss_q)
      service_request <= 1'b1;
    else if (do_poll)
      service_request <= 1'b0;
  end

  // Registered status byte for the outside
  always_ff @(posedge clock)
  begin
    if (rst)
      status_byte <= 8'h00;
    else
      status_byte <= stb_d;
  end

  // Query decode; reads change nothing but the event clears and the serial-poll request clear above
  always_comb
  begin
    resp_d = scpi_status_pkg::ZERO16;
    query_d = 1'b1;
    case (cmd_op)
      scpi_status_pkg::CMD_SERIAL_POLL: resp_d = {8'h00, poll_d};
      scpi_status_pkg::CMD_STB_Q: resp_d = {8'h00, stb_d};
      scpi_status_pkg::CMD_SRE_Q: resp_d = {8'h00, sre_q};
      scpi_status_pkg::CMD_OPER_COND_Q: resp_d = oper_cond_q;
      scpi_status_pkg::CMD_OPER_EVT_Q: resp_d = oper_if.event_q;
      scpi_status_pkg::CMD_OPER_EN_Q: resp_d = oper_if.enable_q;
      scpi_status_pkg::CMD_QUES_COND_Q: resp_d = ques_cond_q;
      scpi_status_pkg::CMD_QUES_EVT_Q: resp_d = ques_if.event_q;
      scpi_status_pkg::CMD_QUES_EN_Q: resp_d = ques_if.enable_q;
      scpi_status_pkg::CMD_ESR_Q: resp_d = std_if.event_q;
      scpi_status_pkg::CMD_ESE_Q: resp_d = std_if.enable_q;
      scpi_status_pkg::CMD_ALARM_COND_Q: resp_d = alarm_cond_q;
      scpi_status_pkg::CMD_ALARM_EVT_Q: resp_d = alarm_if.event_q;
      scpi_status_pkg::CMD_ALARM_EN_Q: resp_d = alarm_if.enable_q;
      scpi_status_pkg::CMD_THR_Q: resp_d = thr_q;
      default: query_d = 1'b0;
    endcase
  end

  // Answer strobe stands one cycle after the command
  always_ff @(posedge clock)
  begin
    if (rst)
      resp_valid <= 1'b0;
    else
      resp_valid <= cmd_valid && query_d;
  end

  // Answer data holds until the next query
  always_ff @(posedge clock)
  begin
    if (rst)
      resp_data <= scpi_status_pkg::ZERO16;
    else if (cmd_valid && query_d)
      resp_data <= resp_d;
  end

  // Scan bit tracks the running input one cycle later
  property p_scan_follows;
    @(posedge clock) disable iff (rst)
    1'b1 |=> oper_cond_q[scpi_status_pkg::OPER_SCAN_BIT] == $past(scan_running);
  endproperty
  a_scan_follows: assert property (p_scan_follows) else $error("scan bit lags");

  // A scan start with no edit in the same cycle drops the edit flag
  property p_cfg_cleared;
    @(posedge clock) disable iff (rst)
    scan_start && !panel_cfg_change |=> !cfg_q;
  endproperty
  a_cfg_cleared: assert property (p_cfg_cleared) else $error("edit flag kept");

  // A held threshold level raises no second event
  property p_mem_once;
    @(posedge clock) disable iff (rst)
    oper_cond_q[scpi_status_pkg::OPER_MEM_BIT] && level_q
      |=> !oper_if.set[scpi_status_pkg::OPER_MEM_BIT];
  endproperty
  a_mem_once: assert property (p_mem_once) else $error("threshold refired");

  // Unused operation positions never carry a one
  property p_oper_unused;
    @(posedge clock) disable iff (rst)
    ((oper_if.event_q | oper_cond_q) & ~scpi_status_pkg::OPER_USED) == scpi_status_pkg::ZERO16;
  endproperty
  a_oper_unused: assert property (p_oper_unused) else $error("unused bit set");

  // Status byte query reports the live master summary
  property p_stb_keeps_mss;
    @(posedge clock) disable iff (rst)
    cmd_valid && (cmd_op == scpi_status_pkg::CMD_STB_Q)
      |=> resp_valid && (resp_data[scpi_status_pkg::STB_MSS_BIT] == $past(mss_d));
  endproperty
  a_stb_keeps_mss: assert property (p_stb_keeps_mss) else $error("summary lost");

  // Enable of the status byte moves only on its own write
  property p_sre_write_only;
    @(posedge clock) disable iff (rst)
    !(cmd_valid && (cmd_op == scpi_status_pkg::CMD_SRE_W)) |=> $stable(sre_q);
  endproperty
  a_sre_write_only: assert property (p_sre_write_only) else $error("enable moved");

  // Queue flag shows the queue state one cycle later
  property p_alarm_queue;
    @(posedge clock) disable iff (rst)
    !do_factory |=>
      alarm_cond_q[scpi_status_pkg::ALARM_QUEUE_BIT] == $past(alarm_queue_not_empty);
  endproperty
  a_alarm_queue: assert property (p_alarm_queue) else $error("queue flag wrong");
endmodule
`default_nettype wire

/* scpi_status_pkg.sv */
// Shared constants, command codes and bit layout of the status register groups
`default_nettype none
package scpi_status_pkg;
  localparam int unsigned REG_W = 16;
  localparam int unsigned STD_W = 8;
  // Operation group bit positions and implemented bits
  localparam int unsigned OPER_SCAN_BIT = 4;
  localparam int unsigned OPER_CFG_BIT = 8;
  localparam int unsigned OPER_MEM_BIT = 9;
  localparam logic [15:0] OPER_USED = 16'h0310;
  // Questionable group: all bits may be driven by the instrument
  localparam logic [15:0] QUES_USED = 16'hFFFF;
  // Standard event group: bits 1 and 6 unused, bit 7 is power on
  localparam logic [15:0] STD_USED = 16'h00BD;
  localparam int unsigned STD_PON_BIT = 7;
  // Alarm group: condition implements only the queue bit
  localparam int unsigned ALARM_QUEUE_BIT = 4;
  localparam logic [15:0] ALARM_USED = 16'h003F;
  // Status byte bit positions
  localparam int unsigned STB_ALARM_BIT = 1;
  localparam int unsigned STB_ERRQ_BIT = 2;
  localparam int unsigned STB_QUES_BIT = 3;
  localparam int unsigned STB_MAV_BIT = 4;
  localparam int unsigned STB_STD_BIT = 5;
  localparam int unsigned STB_MSS_BIT = 6;
  localparam int unsigned STB_OPER_BIT = 7;
  // Memory threshold range, in readings
  localparam logic [15:0] THR_MIN = 16'h0001;
  localparam logic [15:0] THR_MAX = 16'hC350;
  localparam logic [15:0] THR_DEFAULT = 16'h0001;
  localparam logic [15:0] ZERO16 = 16'h0000;
  // Host commands, one per status command or query
  typedef enum logic [4:0] {
    CMD_NOP, CMD_CLS, CMD_PRESET, CMD_FACTORY_RST, CMD_SERIAL_POLL,
    CMD_STB_Q, CMD_SRE_W, CMD_SRE_Q,
    CMD_OPER_COND_Q, CMD_OPER_EVT_Q, CMD_OPER_EN_W, CMD_OPER_EN_Q,
    CMD_QUES_COND_Q, CMD_QUES_EVT_Q, CMD_QUES_EN_W, CMD_QUES_EN_Q,
    CMD_ESR_Q, CMD_ESE_W, CMD_ESE_Q,
    CMD_ALARM_COND_Q, CMD_ALARM_EVT_Q, CMD_ALARM_EN_W, CMD_ALARM_EN_Q,
    CMD_THR_W, CMD_THR_Q
  } cmd_t;
endpackage
`default_nettype wire

/* status_group_if.sv */
// Control and state of one event/enable register group
`default_nettype none
interface status_group_if #(parameter int unsigned W = 16);
  logic [W-1:0] set;
  logic clr_event;
  logic en_we;
  logic en_clr;
  logic [W-1:0] en_wdata;
  logic [W-1:0] event_q;
  logic [W-1:0] enable_q;
  logic summary;
  modport ctrl (output set, output clr_event, output en_we, output en_clr,
    output en_wdata, input event_q, input enable_q, input summary);
  modport grp (input set, input clr_event, input en_we, input en_clr,
    input en_wdata, output event_q, output enable_q, output summary);
endinterface
`default_nettype wire

/* status_group.sv */
// One register group: latched event bits, enable mask and summary
`default_nettype none
module status_group #(
  parameter logic [15:0] USED = 16'hFFFF
) (
  input wire logic clock,
  input wire logic rst,
  status_group_if.grp g
);
  logic [15:0] ev_q;
  logic [15:0] en_q;

  // Event latches; a set in the clearing cycle survives the clear
  for (genvar i = 0; i < 16; i++)
  begin : g_bit
    always_ff @(posedge clock)
    begin
      if (rst || !USED[i])
        ev_q[i] <= 1'b0;
      else if (g.set[i])
        ev_q[i] <= 1'b1;
      else if (g.clr_event)
        ev_q[i] <= 1'b0;
    end
  end

  // Enable mask; stored as written so a query returns the same sum
  always_ff @(posedge clock)
  begin
    if (rst)
      en_q <= scpi_status_pkg::ZERO16;
    else if (g.en_clr)
      en_q <= scpi_status_pkg::ZERO16;
    else if (g.en_we)
      en_q <= g.en_wdata;
  end

  assign g.event_q = ev_q;
  assign g.enable_q = en_q;
  // Combinational so it follows either register at once
  assign g.summary = |(ev_q & en_q);

  property p_latch_holds;
    @(posedge clock) disable iff (rst)
    (ev_q != scpi_status_pkg::ZERO16) && !g.clr_event |=> ((ev_q & $past(ev_q)) == $past(ev_q));
  endproperty
  a_latch_holds: assert property (p_latch_holds) else $error("event bit lost");
endmodule
`default_nettype wire

/* mem_threshold.sv */
// Memory threshold register and re-arming threshold detector
`default_nettype none
module mem_threshold (
  input wire logic clock,
  input wire logic rst,
  input wire logic thr_we,
  input wire logic [15:0] thr_wdata,
  input wire logic [15:0] reading_count,
  output logic [15:0] thr_q,
  output logic level_q
);
  // Threshold store, clamped to the legal reading range
  always_ff @(posedge clock)
  begin
    if (rst)
      thr_q <= scpi_status_pkg::THR_DEFAULT;
    else if (thr_we)
    begin
      if (thr_wdata < scpi_status_pkg::THR_MIN)
        thr_q <= scpi_status_pkg::THR_MIN;
      else if (thr_wdata > scpi_status_pkg::THR_MAX)
        thr_q <= scpi_status_pkg::THR_MAX;
      else
        thr_q <= thr_wdata;
    end
  end

  // Level only; caller latches on its rising edge, so the count must
  // drop below the threshold before another event can fire
  always_ff @(posedge clock)
  begin
    if (rst)
      level_q <= 1'b0;
    else
      level_q <= (reading_count >= thr_q);
  end
endmodule
`default_nettype wire

/* scpi_host_model.sv */
// Host controller model issuing one status command at a time
`default_nettype none
module scpi_host_model (
  input wire logic clock,
  output logic cmd_valid,
  output var scpi_status_pkg::cmd_t cmd_op,
  output logic [15:0] cmd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    cmd_valid = 1'b0;
    cmd_op = scpi_status_pkg::CMD_NOP;
    cmd_data = 16'h0000;
  end
  // Idle gap first so condition inputs settle; masks go out as weighted sums
  task automatic send(input scpi_status_pkg::cmd_t op, input logic [15:0] d);
    repeat (3) @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_data <= d;
    @(posedge clock);
    cmd_valid <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
endmodule
`default_nettype wire

/* scpi_status_tb.sv */
// Self-checking bench for the status register groups
`default_nettype none
module scpi_status_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, rst, scan, cfg, aq, cv, rv, sr;
  logic [15:0] ques, rd, cd, ev, rc;
  logic [31:0] lf;
  logic [7:0] stb, se;
  scpi_status_pkg::cmd_t op;
  logic [15:0] expq[$];
  int err_count = 0;
  int checks = 0;
  scpi_host_model host (.clock(clock), .cmd_valid(cv), .cmd_op(op), .cmd_data(cd));
  scpi_status DUT (.clock(clock), .rst(rst), .cmd_valid(cv), .cmd_op(op), .cmd_data(cd),
    .scan_running(scan), .panel_cfg_change(cfg), .reading_count(rc),
    .ques_cond_in(ques), .std_event_in(se), .alarm_event_in(16'h0000),
    .alarm_queue_not_empty(aq), .error_queue_not_empty(1'b0),
    .message_available(1'b0), .resp_valid(rv), .resp_data(rd), .status_byte(stb),
    .service_request(sr));
  // One step of the stimulus shift register
  function automatic logic [31:0] next_lf(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checks++;
    if (s !== e)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic complete_run();
    if (err_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Query note goes on the queue before the command leaves
  task automatic ask(input scpi_status_pkg::cmd_t o, input logic [15:0] e);
    expq.push_back(e);
    host.send(o, 16'h0000);
  endtask
  // Oldest note against each answer; a stray answer has no note
  always @(posedge clock)
    if (rv === 1'b1)
    begin
      ev = (expq.size() > 0) ? expq.pop_front() : 16'hxxxx;
      chk("resp_data", ev, rd);
    end
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial
  begin
    {rst, scan, cfg, aq, ques, se, rc} = {4'h8, 16'h0000, 8'h00, 16'h0000};
    lf = 32'h0000_bb42;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    ask(scpi_status_pkg::CMD_OPER_EN_Q, 16'h0000);
    cfg <= 1'b1;
    @(posedge clock);
    cfg <= 1'b0;
    ask(scpi_status_pkg::CMD_OPER_COND_Q, 16'h0100);
    ask(scpi_status_pkg::CMD_OPER_EVT_Q, 16'h0100);
    ask(scpi_status_pkg::CMD_OPER_EVT_Q, 16'h0000);
    scan <= 1'b1;
    ask(scpi_status_pkg::CMD_OPER_COND_Q, 16'h0010);
    host.send(scpi_status_pkg::CMD_OPER_EN_W, 16'h0310);
    ask(scpi_status_pkg::CMD_OPER_EN_Q, 16'h0310);
    chk("oper_summary", 16'h0001, {15'h0000, stb[7]});
    host.send(scpi_status_pkg::CMD_SRE_W, 16'h0028);
    host.send(scpi_status_pkg::CMD_ESE_W, 16'h003C);
    host.send(scpi_status_pkg::CMD_QUES_EN_W, 16'h00F0);
    host.send(scpi_status_pkg::CMD_CLS, 16'h0000);
    ask(scpi_status_pkg::CMD_QUES_EN_Q, 16'h00F0);
    host.send(scpi_status_pkg::CMD_PRESET, 16'h0000);
    ask(scpi_status_pkg::CMD_OPER_EN_Q, 16'h0000);
    ask(scpi_status_pkg::CMD_SRE_Q, 16'h0028);
    ask(scpi_status_pkg::CMD_ESE_Q, 16'h003C);
    ask(scpi_status_pkg::CMD_QUES_EN_Q, 16'h0000);
    lf = next_lf(lf);
    ques <= lf[15:0];
    ask(scpi_status_pkg::CMD_QUES_COND_Q, lf[15:0]);
    ask(scpi_status_pkg::CMD_QUES_EVT_Q, lf[15:0]);
    ask(scpi_status_pkg::CMD_QUES_EVT_Q, 16'h0000);
    aq <= 1'b1;
    ask(scpi_status_pkg::CMD_ALARM_COND_Q, 16'h0010);
    aq <= 1'b0;
    ask(scpi_status_pkg::CMD_ALARM_COND_Q, 16'h0000);
    // Threshold event fires once per crossing
    host.send(scpi_status_pkg::CMD_THR_W, 16'h0003);
    ask(scpi_status_pkg::CMD_THR_Q, 16'h0003);
    rc <= 16'h0003;
    ask(scpi_status_pkg::CMD_OPER_EVT_Q, 16'h0200);
    ask(scpi_status_pkg::CMD_OPER_EVT_Q, 16'h0000);
    rc <= 16'h0000;
    repeat (4) @(posedge clock);
    rc <= 16'h0003;
    ask(scpi_status_pkg::CMD_OPER_EVT_Q, 16'h0200);
    // Standard event reaches the status byte and raises a request
    se <= 8'h10;
    @(posedge clock);
    se <= 8'h00;
    ask(scpi_status_pkg::CMD_STB_Q, 16'h0060);
    chk("status_byte", 16'h0060, {8'h00, stb});
    chk("service_request", 16'h0001, {15'h0000, sr});
    ask(scpi_status_pkg::CMD_SERIAL_POLL, 16'h0060);
    ask(scpi_status_pkg::CMD_STB_Q, 16'h0060);
    chk("service_request", 16'h0000, {15'h0000, sr});
    ask(scpi_status_pkg::CMD_ESR_Q, 16'h0010);
    ask(scpi_status_pkg::CMD_ESR_Q, 16'h0010);
    host.send(scpi_status_pkg::CMD_CLS, 16'h0000);
    ask(scpi_status_pkg::CMD_ESR_Q, 16'h0000);
    chk("status_byte", 16'h0000, {8'h00, stb});
    // Unanswered notes count against the run
    repeat (20) @(posedge clock);
    if (expq.size() > 0)
      err_count++;
    complete_run();
  end
endmodule
`default_nettype wire
